//--- hdl/papwr_map.svh
`ifndef PAPWR_MAP_SVH
`define PAPWR_MAP_SVH

// Register addresses on the serial register port
`define PAPWR_ADDR_BLK_DIV 8'h1a
`define PAPWR_ADDR_STAGES 8'h1b

// Reset values
`define PAPWR_RST_BLK_DIV 8'h00
`define PAPWR_RST_STAGES 8'h00

// Field positions in the block select and divider high register
`define PAPWR_BLK_B_HI 7
`define PAPWR_BLK_B_LO 5
`define PAPWR_BLK_A_HI 4
`define PAPWR_BLK_A_LO 2
`define PAPWR_DIV_HI_HI 1
`define PAPWR_DIV_HI_LO 0

// Field positions in the stage count register
`define PAPWR_CNT_B_HI 7
`define PAPWR_CNT_B_LO 4
`define PAPWR_CNT_A_HI 3
`define PAPWR_CNT_A_LO 0

// Stage count saturation point and number of stages
`define PAPWR_MAX_STAGES 4'hb
`define PAPWR_NUM_STAGES 11
`define PAPWR_NUM_BLOCKS 3

`endif

//--- hdl/papwr_pkg.sv
package papwr_pkg;

    // Number of enabled PA stages
    typedef logic [3:0] papwr_count_t;

    // Which of the two alternative settings is in use
    typedef enum logic {
        PAPWR_SEL_A = 1'b0,
        PAPWR_SEL_B = 1'b1
    } papwr_sel_t;

endpackage

//--- hdl/papwr_cfg.sv
`include "papwr_map.svh"

// Summary of operation
// - Bits 7:5 of the first register enable PA blocks 0..2, setting b.
// - Bits 4:2 of the first register enable PA blocks 0..2, setting a.
// - Bits 1:0 of the first register give shaping divider bits 9:8; ratio is value+1.
// - Upper nibble of second register is stage count b, saturating at eleven.
// - Lower nibble of second register is stage count a, saturating at eleven.
// - Exactly as many PA stages turn on as the selected count says.
// - Divider low byte comes from outside and joins the two upper bits here.
// - Armed fail-safe with parity, brownout or lock error forces all PA drivers off.
module papwr_cfg #(
    // Number of PA stages driven by the thermometer decode
    parameter int NUM_STAGES = `PAPWR_NUM_STAGES
) (
    // System clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Serial register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_hit_out,
    // Divider low byte, setting choice and fail-safe inputs
    input wire logic [7:0] ask_ratio_low_in,
    input wire papwr_pkg::papwr_sel_t setting_sel_in,
    input wire logic failsafe_disable_bit_in,
    input wire logic parity_err_in,
    input wire logic brownout_err_in,
    input wire logic lock_err_in,
    input wire logic shaping_run_in,
    // PA drive and shaping outputs
    output logic [2:0] pa_block_en_out,
    output logic [NUM_STAGES-1:0] pa_stage_en_out,
    output logic [3:0] output_stage_count_out,
    output logic [9:0] ask_shaping_clock_ratio_out,
    output logic shaping_tick_out
);
    import papwr_pkg::*;

    // Register contents
    logic [7:0] blk_div_q;
    logic [7:0] stages_q;
    logic [7:0] rdata_q;

    // Fields of both settings, raw and clipped
    logic [2:0] pa_block_select_a;
    logic [2:0] pa_block_select_b;
    papwr_count_t output_stage_count_a;
    papwr_count_t output_stage_count_b;
    papwr_count_t count_sat_a;
    papwr_count_t count_sat_b;

    // Setting in use and the fail-safe condition
    papwr_count_t count_sel;
    logic [2:0] blk_sel;
    logic failsafe_trip;

    // Registered PA drive
    logic [2:0] blk_en_q;
    logic [NUM_STAGES-1:0] stage_en_d;
    logic [NUM_STAGES-1:0] stage_en_q;
    papwr_count_t count_q;

    // Shaping divider state
    logic [9:0] ratio_q;
    logic [9:0] div_cnt_q;
    logic tick_q;

    // Block select and divider high register; raw bits are kept so that
    // software reads back exactly what it wrote
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            blk_div_q <= `PAPWR_RST_BLK_DIV;
        end else if (reg_wr_in && (reg_addr_in == `PAPWR_ADDR_BLK_DIV)) begin
            blk_div_q <= reg_wdata_in;
        end
    end

    // Stage count register; nibbles above eleven are stored raw and only
    // clipped where they are used, so a readback never surprises software
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            stages_q <= `PAPWR_RST_STAGES;
        end else if (reg_wr_in && (reg_addr_in == `PAPWR_ADDR_STAGES)) begin
            stages_q <= reg_wdata_in;
        end
    end

    // Read data lands one cycle after the read strobe; unmapped reads give zero.
    // A read in the same cycle as a write to that register returns the old value.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `PAPWR_ADDR_BLK_DIV: rdata_q <= blk_div_q;
                `PAPWR_ADDR_STAGES: rdata_q <= stages_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // Read data straight from its flop
    assign reg_rdata_out = rdata_q;

    // Address decode alone; tells the port whether this block owns the address
    assign reg_hit_out = (reg_addr_in == `PAPWR_ADDR_BLK_DIV) ||
                         (reg_addr_in == `PAPWR_ADDR_STAGES);

    // Field extraction; both settings are decoded all the time so that a
    // change of setting needs no register access
    assign pa_block_select_b = blk_div_q[`PAPWR_BLK_B_HI:`PAPWR_BLK_B_LO];
    assign pa_block_select_a = blk_div_q[`PAPWR_BLK_A_HI:`PAPWR_BLK_A_LO];
    assign output_stage_count_b = stages_q[`PAPWR_CNT_B_HI:`PAPWR_CNT_B_LO];
    assign output_stage_count_a = stages_q[`PAPWR_CNT_A_HI:`PAPWR_CNT_A_LO];

    // Counts above eleven behave as eleven; saturate on use, not on write,
    // which costs two comparators but keeps readback honest
    assign count_sat_b = (output_stage_count_b > `PAPWR_MAX_STAGES) ?
                         `PAPWR_MAX_STAGES : output_stage_count_b;
    assign count_sat_a = (output_stage_count_a > `PAPWR_MAX_STAGES) ?
                         `PAPWR_MAX_STAGES : output_stage_count_a;

    // Setting selection; the same input picks both the blocks and the count
    // so the two can never come from different settings
    assign count_sel = (setting_sel_in == PAPWR_SEL_B) ? count_sat_b : count_sat_a;
    assign blk_sel = (setting_sel_in == PAPWR_SEL_B) ? pa_block_select_b :
                     pa_block_select_a;

    // Fail-safe is armed while the disable bit is low. The error inputs are
    // levels; latching them belongs to the status register outside, so the
    // trip lasts only while an error stands
    assign failsafe_trip = !failsafe_disable_bit_in &&
                           (parity_err_in || brownout_err_in || lock_err_in);

    // Thermometer decode: stage i is on when the count exceeds i, so the
    // number of stages on always equals the count
    for (genvar i = 0; i < NUM_STAGES; i++) begin : g_stage
        assign stage_en_d[i] = (count_sel > 4'(i));
    end

    // PA block enables; a trip overrides every setting held here, and the
    // enables come from a flop so the PA never sees a decode glitch
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            blk_en_q <= 3'h0;
        end else if (failsafe_trip) begin
            blk_en_q <= 3'h0;
        end else begin
            blk_en_q <= blk_sel;
        end
    end

    // PA stage enables, thermometer coded from the selected count
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            stage_en_q <= '0;
        end else if (failsafe_trip) begin
            stage_en_q <= '0;
        end else begin
            stage_en_q <= stage_en_d;
        end
    end

    // Selected count as applied; it reads zero while tripped so the reported
    // count always matches the stages actually driven
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            count_q <= 4'h0;
        end else if (failsafe_trip) begin
            count_q <= 4'h0;
        end else begin
            count_q <= count_sel;
        end
    end

    // Drive outputs straight from their flops
    assign pa_block_en_out = blk_en_q;
    assign pa_stage_en_out = stage_en_q;
    assign output_stage_count_out = count_q;

    // Full ten-bit shaping ratio; the low byte lives in a register outside
    // this block and is taken as a level
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ratio_q <= 10'h000;
        end else begin
            ratio_q <= {blk_div_q[`PAPWR_DIV_HI_HI:`PAPWR_DIV_HI_LO], ask_ratio_low_in};
        end
    end

    // Ratio as seen by the shaping logic
    assign ask_shaping_clock_ratio_out = ratio_q;

    // Shaping divider counter: field value n divides by n+1. The compare is
    // greater-or-equal, so a ratio lowered below the running count ends the
    // period at the next edge instead of letting the counter run round
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            div_cnt_q <= 10'h000;
        end else if (!shaping_run_in) begin
            div_cnt_q <= 10'h000;
        end else if (div_cnt_q >= ratio_q) begin
            div_cnt_q <= 10'h000;
        end else begin
            div_cnt_q <= div_cnt_q + 10'h001;
        end
    end

    // Shaping tick: one cycle wide for a ratio above zero (held high at zero), in the cycle after the counter reaches
    // the ratio; stopping the divider clears it at the next edge
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            tick_q <= 1'b0;
        end else if (!shaping_run_in) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_cnt_q >= ratio_q);
        end
    end

    // Tick leaves from its flop
    assign shaping_tick_out = tick_q;

endmodule

//--- bench/papwr_cfg_checker.sv
module papwr_cfg_checker #(
    parameter int NUM_STAGES = 11
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] ask_ratio_low_in,
    input wire papwr_pkg::papwr_sel_t setting_sel_in,
    input wire logic failsafe_disable_bit_in,
    input wire logic parity_err_in,
    input wire logic brownout_err_in,
    input wire logic lock_err_in,
    input wire logic shaping_run_in,
    input wire logic [2:0] pa_block_en_out,
    input wire logic [NUM_STAGES-1:0] pa_stage_en_out,
    input wire logic [3:0] output_stage_count_out,
    input wire logic [9:0] ask_shaping_clock_ratio_out,
    input wire logic shaping_tick_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh_q;
    wire trip = !failsafe_disable_bit_in && (parity_err_in || brownout_err_in || lock_err_in);
    wire [2:0] blk = setting_sel_in ? sh_q[7:5] : sh_q[4:2];
    wire [3:0] nib = setting_sel_in ? sh_q[15:12] : sh_q[11:8];
    wire [3:0] sat = nib > 4'hb ? 4'hb : nib;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    // Shadow of both registers; the drive outputs lag it by one edge
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) sh_q <= 16'h0000;
        else if (reg_wr_in && reg_addr_in == 8'h1a) sh_q[7:0] <= reg_wdata_in;
        else if (reg_wr_in && reg_addr_in == 8'h1b) sh_q[15:8] <= reg_wdata_in;
    end
    property p_blk; !trip |=> pa_block_en_out == $past(blk); endproperty
    a_blk: assert property (p_blk) else $error("bad block enables");
    property p_cnt; !trip |=> output_stage_count_out == $past(sat); endproperty
    a_cnt: assert property (p_cnt) else $error("bad stage count");
    property p_max; output_stage_count_out <= 4'hb; endproperty
    a_max: assert property (p_max) else $error("stage count above eleven");
    property p_thm;
        pa_stage_en_out == ~({NUM_STAGES{1'b1}} << output_stage_count_out);
    endproperty
    a_thm: assert property (p_thm) else $error("stage enables not count");
    property p_trip; trip |=> pa_block_en_out == 3'h0 && pa_stage_en_out == '0; endproperty
    a_trip: assert property (p_trip) else $error("drivers on in trip");
    property p_tcnt; $past(trip) |-> output_stage_count_out == 4'h0; endproperty
    a_tcnt: assert property (p_tcnt) else $error("count on in trip");
    property p_rat;
        !$past(sys_rst_in) |-> ask_shaping_clock_ratio_out == {$past(sh_q[1:0]),
            $past(ask_ratio_low_in)};
    endproperty
    a_rat: assert property (p_rat) else $error("bad divider ratio");
    property p_run; !shaping_run_in |=> !shaping_tick_out; endproperty
    a_run: assert property (p_run) else $error("tick while stopped");
endmodule

bind papwr_cfg papwr_cfg_checker #(.NUM_STAGES(NUM_STAGES)) u_chk (.*);

//--- bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import papwr_pkg::*;
    logic clk_sys_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, shaping_run_in = 0;
    logic failsafe_disable_bit_in = 0, parity_err_in = 0, brownout_err_in = 0, lock_err_in = 0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, ask_ratio_low_in = 8'h5a;
    papwr_sel_t setting_sel_in = PAPWR_SEL_A;
    logic [7:0] reg_rdata_out;
    logic reg_hit_out, shaping_tick_out;
    logic [2:0] pa_block_en_out;
    logic [10:0] pa_stage_en_out;
    logic [3:0] output_stage_count_out;
    logic [9:0] ask_shaping_clock_ratio_out;
    int n_fail = 0, num_checks = 0;
    papwr_cfg u_dut (.*);
    initial forever #2 clk_sys_in = ~clk_sys_in;
    // Inputs move 1 ns after the edge so no race with the design's sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        cyc(1);
        reg_wr_in = 0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr_in = a;
        reg_rd_in = 1;
        cyc(1);
        reg_rd_in = 0;
        chk("rdata", {8'h00, e}, {8'h00, reg_rdata_out});
        chk("hit", {15'h0, (a == 8'h1a) || (a == 8'h1b)}, {15'h0, reg_hit_out});
        cyc(1);
    endtask
    task automatic t_regs();
        rd(8'h1a, 8'h00);
        rd(8'h1b, 8'h00);
        wr(8'h1c, 8'hff);
        rd(8'h1c, 8'h00);
        wr(8'h1a, 8'hc5);
        rd(8'h1a, 8'hc5);
        chk("blk_a", 16'h1, pa_block_en_out);
        setting_sel_in = PAPWR_SEL_B;
        cyc(2);
        chk("blk_b", 16'h6, pa_block_en_out);
        chk("ratio", 16'h15a, ask_shaping_clock_ratio_out);
    endtask
    // Every nibble value in both halves, so saturation is hit from both sides
    task automatic t_counts();
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            wr(8'h1b, {4'(15 - i), 4'(i)});
            for (int s = 0; s < 2; s++) begin
                setting_sel_in = papwr_sel_t'(s);
                v = s ? 4'(15 - i) : 4'(i);
                v = v > 4'hb ? 4'hb : v;
                cyc(2);
                chk("count", 16'(v), output_stage_count_out);
                chk("stages", (16'h1 << v) - 16'h1, pa_stage_en_out);
            end
        end
    endtask
    task automatic t_failsafe();
        setting_sel_in = PAPWR_SEL_B;
        wr(8'h1b, 8'h77);
        for (int k = 0; k < 3; k++) begin
            {lock_err_in, brownout_err_in, parity_err_in} = 3'h1 << k;
            failsafe_disable_bit_in = 0;
            cyc(2);
            chk("trip_count", 16'h0, output_stage_count_out);
            chk("trip_blocks", 16'h0, pa_block_en_out);
            chk("trip_stages", 16'h0, pa_stage_en_out);
            failsafe_disable_bit_in = 1;
            cyc(2);
            chk("off_count", 16'h7, output_stage_count_out);
            chk("off_blocks", 16'h6, pa_block_en_out);
            chk("off_stages", 16'h7f, pa_stage_en_out);
        end
        {lock_err_in, brownout_err_in, parity_err_in} = 3'h0;
    endtask
    task automatic t_tick();
        int n;
        ask_ratio_low_in = 8'h03;
        wr(8'h1a, 8'h00);
        shaping_run_in = 1;
        for (n = 0; n < 20 && shaping_tick_out !== 1'b1; n++) cyc(1);
        cyc(1);
        for (n = 1; n < 20 && shaping_tick_out !== 1'b1; n++) cyc(1);
        chk("tick_period", 16'h4, 16'(n));
        if (n == 20) tally_and_finish();
        shaping_run_in = 0;
        cyc(2);
        chk("tick_idle", 16'h0, {15'h0, shaping_tick_out});
    endtask
    // Reset in mid-run must clear both registers and every drive output
    task automatic t_reset();
        wr(8'h1a, 8'hff);
        wr(8'h1b, 8'hbb);
        sys_rst_in = 1;
        cyc(2);
        chk("rst_blocks", 16'h0, pa_block_en_out);
        chk("rst_stages", 16'h0, pa_stage_en_out);
        chk("rst_count", 16'h0, output_stage_count_out);
        chk("rst_ratio", 16'h0, ask_shaping_clock_ratio_out);
        chk("rst_rdata", 16'h0, reg_rdata_out);
        sys_rst_in = 0;
        rd(8'h1a, 8'h00);
        rd(8'h1b, 8'h00);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        cyc(5);
        sys_rst_in = 0;
        t_regs();
        t_counts();
        t_failsafe();
        t_tick();
        t_reset();
        tally_and_finish();
    end
endmodule
